// ### hdl/cowl_slave.sv
// One-wire cascaded LED switch slave: frame decoder, pass-through, buffer, latch and fault flag.
`timescale 1ns/1ps
`default_nettype none

module cowl_slave #(
  parameter int RESET_CYCLES = cowl_pkg::RESET_CYC,
  parameter int SYNC_TIMEOUT_CYCLES = cowl_pkg::SYNC_TIMEOUT_CYC,
  parameter int GAP_MAX_CYCLES = cowl_pkg::GAP_MAX_CYC,
  parameter int BIT_PERIOD_MIN_CYCLES = cowl_pkg::BIT_PERIOD_MIN_CYC,
  parameter int BIT_PERIOD_MAX_CYCLES = cowl_pkg::BIT_PERIOD_MAX_CYC,
  parameter int DEGLITCH_CYCLES = cowl_pkg::DEGLITCH_CYC
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic data_line_in,
  output logic data_line_out,
  input wire logic open_detect_on_threshold_in,
  input wire logic open_detect_off_threshold_in,
  input wire logic open_string_in,
  input wire logic shared_fault_flag_n_in,
  output logic shared_fault_flag_n_out,
  output logic shared_fault_flag_n_oe_out,
  output logic full_current_out,
  output logic recovery_test_current_out,
  output logic switch_closed_out
);

  localparam int EW = cowl_pkg::EDGE_W;
  localparam int LW = cowl_pkg::LONG_W;
  localparam logic [LW-1:0] SYNC_TO_L = LW'(SYNC_TIMEOUT_CYCLES);
  localparam logic [LW-1:0] GAP_MAX_L = LW'(GAP_MAX_CYCLES);
  localparam logic [EW-1:0] TC_LO = EW'(BIT_PERIOD_MIN_CYCLES / 4 * int'(cowl_pkg::Q_PER_LO));
  localparam logic [EW-1:0] TC_HI = EW'(BIT_PERIOD_MAX_CYCLES / 4 * int'(cowl_pkg::Q_PER_HI));

  typedef struct packed {
    cowl_pkg::cowl_rx_state_t st;
    cowl_pkg::cowl_cmd_t cmd;
    logic din;
    logic [EW-1:0] cnt;
    logic [EW-1:0] tc;
    logic [1:0] nfall;
    logic [LW-1:0] lng;
    logic buf_val;
    logic buf_full;
    logic sw_closed;
    logic led_on;
    logic det_en;
    logic dout;
    logic full_cur;
    logic rtr_cur;
    logic flag_oe;
  } cowl_core_t;

  localparam cowl_core_t CORE_RST = '{
    st: cowl_pkg::COWL_IDLE,
    cmd: cowl_pkg::COWL_CMD_OFF,
    din: 1'b1,
    dout: 1'b1,
    default: '0
  };

  cowl_core_t q;
  cowl_core_t d;
  logic fall;
  logic rise;
  logic line_reset;
  logic open_fault;
  logic [EW-1:0] quarter;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when x lies in [lo*q, hi*q), q being a quarter bit period.
  function automatic logic cowl_in_band(input logic [EW-1:0] x, input logic [EW-1:0] qp,
                                        input logic [3:0] lo, input logic [3:0] hi);
    logic [EW+3:0] lo_lim;
    logic [EW+3:0] hi_lim;
    lo_lim = {4'h0, qp} * {{EW{1'b0}}, lo};
    hi_lim = {4'h0, qp} * {{EW{1'b0}}, hi};
    return ({4'h0, x} >= lo_lim) && ({4'h0, x} < hi_lim);
  endfunction

  // Line edges against the previous sampled level.
  assign fall = q.din & ~data_line_in;
  assign rise = ~q.din & data_line_in;
  assign quarter = q.tc >> 2;

  // Long-low detector for the line reset.
  cowl_hold_timer #(.HOLD_CYCLES(RESET_CYCLES)) u_reset_timer (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .level_in(~data_line_in),
    .held_out(line_reset)
  );

  // Deglitch filter for the open-string condition, only while detection is enabled.
  cowl_hold_timer #(.HOLD_CYCLES(DEGLITCH_CYCLES)) u_open_deglitch (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .level_in(q.det_en & open_string_in),
    .held_out(open_fault)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Frame decoder, buffer and switch control, fault and output drive.
  always_comb begin
    d = q;
    d.din = data_line_in;
    if (q.cnt != '1) begin
      d.cnt = q.cnt + 1'b1;
    end
    case (q.st)
      cowl_pkg::COWL_IDLE: begin
        if (fall) begin
          d.st = cowl_pkg::COWL_SYNC;
          d.cnt = '0;
          d.nfall = '0;
          d.lng = '0;
        end
      end
      cowl_pkg::COWL_SYNC: begin
        d.lng = q.lng + 1'b1;
        if (q.lng >= SYNC_TO_L) begin
          d.st = cowl_pkg::COWL_IDLE;
        end else if (fall) begin
          d.cnt = '0;
          if (q.nfall == 2'h0) begin
            // First sync period sets the bit period.
            d.tc = q.cnt;
            d.nfall = 2'h1;
            if (q.cnt < TC_LO || q.cnt > TC_HI) begin
              d.st = cowl_pkg::COWL_IDLE;
            end
          end else if (!cowl_in_band(q.cnt, quarter, cowl_pkg::Q_PER_LO, cowl_pkg::Q_PER_HI)) begin
            d.st = cowl_pkg::COWL_IDLE;
          end else if (q.nfall == 2'h2) begin
            d.st = cowl_pkg::COWL_SYNC_END;
          end else begin
            d.nfall = q.nfall + 1'b1;
          end
        end else if (q.cnt > TC_HI) begin
          d.st = cowl_pkg::COWL_IDLE;
        end
      end
      cowl_pkg::COWL_SYNC_END: begin
        // Last sync low half; its rise completes the sync.
        if (rise) begin
          d.st = cowl_pkg::COWL_GAP;
          d.cnt = '0;
          d.lng = '0;
        end else if (q.cnt >= q.tc) begin
          d.st = cowl_pkg::COWL_IDLE;
        end
      end
      cowl_pkg::COWL_GAP: begin
        d.lng = q.lng + 1'b1;
        if (q.lng >= GAP_MAX_L) begin
          d.st = cowl_pkg::COWL_IDLE;
        end else if (fall) begin
          d.st = cowl_pkg::COWL_DLOW;
          d.cnt = '0;
        end
      end
      cowl_pkg::COWL_DLOW: begin
        // Low length picks the frame: half period off, one period on, two latch.
        if (rise) begin
          d.cnt = '0;
          if (cowl_in_band(q.cnt, quarter, cowl_pkg::Q_ZERO, cowl_pkg::Q_SHORT_HI)) begin
            d.st = cowl_pkg::COWL_DHIGH;
          end else if (cowl_in_band(q.cnt, quarter, cowl_pkg::Q_SHORT_HI, cowl_pkg::Q_ON_HI)) begin
            d.st = cowl_pkg::COWL_STOP;
            d.cmd = cowl_pkg::COWL_CMD_ON;
          end else if (cowl_in_band(q.cnt, quarter, cowl_pkg::Q_ON_HI, cowl_pkg::Q_LATCH_HI)) begin
            d.st = cowl_pkg::COWL_STOP;
            d.cmd = cowl_pkg::COWL_CMD_LATCH;
          end else begin
            d.st = cowl_pkg::COWL_IDLE;
          end
        end else if (!cowl_in_band(q.cnt, quarter, cowl_pkg::Q_ZERO, cowl_pkg::Q_LATCH_HI)) begin
          d.st = cowl_pkg::COWL_IDLE;
        end
      end
      cowl_pkg::COWL_DHIGH: begin
        if (fall) begin
          d.cnt = '0;
          if (cowl_in_band(q.cnt, quarter, cowl_pkg::Q_PER_LO, cowl_pkg::Q_PER_HI)) begin
            d.st = cowl_pkg::COWL_DLOW2;
          end else begin
            d.st = cowl_pkg::COWL_IDLE;
          end
        end else if (!cowl_in_band(q.cnt, quarter, cowl_pkg::Q_ZERO, cowl_pkg::Q_PER_HI)) begin
          d.st = cowl_pkg::COWL_IDLE;
        end
      end
      cowl_pkg::COWL_DLOW2: begin
        if (rise) begin
          d.cnt = '0;
          d.cmd = cowl_pkg::COWL_CMD_OFF;
          d.st = cowl_pkg::COWL_STOP;
          if (!cowl_in_band(q.cnt, quarter, cowl_pkg::Q_ZERO, cowl_pkg::Q_SHORT_HI)) begin
            d.st = cowl_pkg::COWL_IDLE;
          end
        end else if (!cowl_in_band(q.cnt, quarter, cowl_pkg::Q_ZERO, cowl_pkg::Q_SHORT_HI)) begin
          d.st = cowl_pkg::COWL_IDLE;
        end
      end
      cowl_pkg::COWL_STOP: begin
        // Stop must stay high for one and a half periods before the frame is acted on.
        if (fall) begin
          d.st = cowl_pkg::COWL_IDLE;
        end else if (!cowl_in_band(q.cnt, quarter, cowl_pkg::Q_ZERO, cowl_pkg::Q_STOP)) begin
          d.st = cowl_pkg::COWL_IDLE;
          if (q.cmd == cowl_pkg::COWL_CMD_LATCH) begin
            if (q.buf_full) begin
              d.led_on = q.buf_val;
            end
            d.buf_full = 1'b0;
            d.sw_closed = 1'b0;
          end else if (!q.buf_full) begin
            d.buf_val = (q.cmd == cowl_pkg::COWL_CMD_ON);
            d.buf_full = 1'b1;
            d.sw_closed = 1'b1;
          end
          // A full buffer leaves on/off frames to pass through untouched.
        end
      end
      default: begin
        d.st = cowl_pkg::COWL_IDLE;
      end
    endcase
    // A long low aborts everything in progress and opens the switch.
    if (line_reset) begin
      d.st = cowl_pkg::COWL_IDLE;
      d.buf_full = 1'b0;
      d.sw_closed = 1'b0;
    end
    // Open detection enable with hysteresis from two threshold comparators.
    if (open_detect_on_threshold_in) begin
      d.det_en = 1'b1;
    end else if (open_detect_off_threshold_in) begin
      d.det_en = 1'b0;
    end
    // Pass-through: an open switch holds the downstream line at idle high.
    d.dout = d.sw_closed ? data_line_in : 1'b1;
    // Fault drive and current source control.
    d.flag_oe = open_fault;
    d.full_cur = q.led_on & ~open_fault & shared_fault_flag_n_in;
    d.rtr_cur = q.led_on & open_fault;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register and outputs.

  // Reset leaves standby, switch open and output off.
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs taken directly from the state register, flag data tied low; the flag pin only ever pulls low.
  assign data_line_out = q.dout;
  assign shared_fault_flag_n_out = 1'b0;
  assign shared_fault_flag_n_oe_out = q.flag_oe;
  assign full_current_out = q.full_cur;
  assign recovery_test_current_out = q.rtr_cur;
  assign switch_closed_out = q.sw_closed;

endmodule // cowl_slave

`default_nettype wire

// ### hdl/cowl_pkg.sv
// Shared constants and types for the cascaded one-wire LED switch slave.
package cowl_pkg;

  // System clock rate and derived cycle scales.
  localparam int CLK_HZ = 200_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1_000;

  // Times in their own units.
  localparam int RESET_TIME_MS = 12;
  localparam int SYNC_TIMEOUT_MS = 9;
  localparam int GAP_MAX_MS = 10;
  localparam int BIT_PERIOD_MIN_US = 10;
  localparam int BIT_PERIOD_MAX_US = 100;
  localparam int FAULT_DEGLITCH_TIME_US = 10;

  // Cycle counts; every figure divides evenly at 200 MHz, so no rounding is needed.
  localparam int RESET_CYC = RESET_TIME_MS * CYC_PER_MS;
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_MS * CYC_PER_MS;
  localparam int GAP_MAX_CYC = GAP_MAX_MS * CYC_PER_MS;
  localparam int BIT_PERIOD_MIN_CYC = BIT_PERIOD_MIN_US * CYC_PER_US;
  localparam int BIT_PERIOD_MAX_CYC = BIT_PERIOD_MAX_US * CYC_PER_US;
  localparam int DEGLITCH_CYC = FAULT_DEGLITCH_TIME_US * CYC_PER_US;

  // Counter widths: edge timer (up to 65535 cycles) and long timer (up to about 21 ms).
  localparam int EDGE_W = 16;
  localparam int LONG_W = 22;

  // Pulse classification limits in quarters of the measured bit period.
  localparam logic [3:0] Q_ZERO = 4'h0;
  localparam logic [3:0] Q_SHORT_HI = 4'h3;
  localparam logic [3:0] Q_ON_HI = 4'h6;
  localparam logic [3:0] Q_LATCH_HI = 4'hA;
  localparam logic [3:0] Q_PER_LO = 4'h3;
  localparam logic [3:0] Q_PER_HI = 4'h5;
  localparam logic [3:0] Q_STOP = 4'h6;

  // Receive sequencer states.
  typedef enum logic [2:0] {
    COWL_IDLE,
    COWL_SYNC,
    COWL_SYNC_END,
    COWL_GAP,
    COWL_DLOW,
    COWL_DHIGH,
    COWL_DLOW2,
    COWL_STOP
  } cowl_rx_state_t;

  // Decoded frame kinds.
  typedef enum logic [1:0] {
    COWL_CMD_ON,
    COWL_CMD_OFF,
    COWL_CMD_LATCH
  } cowl_cmd_t;

endpackage

// ### hdl/cowl_hold_timer.sv
// Level hold timer: flags a level that has stood for a set number of cycles.
`timescale 1ns/1ps
`default_nettype none

module cowl_hold_timer #(
  parameter int HOLD_CYCLES = 16
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic level_in,
  output logic held_out
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(HOLD_CYCLES);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic held;
  } cowl_hold_t;

  cowl_hold_t q;
  cowl_hold_t d;

  // Count consecutive cycles of the level; any break restarts the count.
  always_comb begin
    d = q;
    if (!level_in) begin
      d.cnt = '0;
    end else if (q.cnt != LIMIT) begin
      d.cnt = q.cnt + 1'b1;
    end
    d.held = level_in && (d.cnt == LIMIT);
  end

  // State register.
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign held_out = q.held;

endmodule // cowl_hold_timer

`default_nettype wire

// ### verif/cowl_slave_checker.sv
// Port-level assertions for the one-wire LED switch slave.
`timescale 1ns/1ps
`default_nettype none
module cowl_slave_checker #(
  parameter int RESET_CYCLES = 200,
  parameter int DEGLITCH_CYCLES = 8
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic data_line_in,
  input wire logic data_line_out,
  input wire logic open_detect_on_threshold_in,
  input wire logic open_detect_off_threshold_in,
  input wire logic open_string_in,
  input wire logic shared_fault_flag_n_in,
  input wire logic shared_fault_flag_n_out,
  input wire logic shared_fault_flag_n_oe_out,
  input wire logic full_current_out,
  input wire logic recovery_test_current_out,
  input wire logic switch_closed_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic [31:0] low_cnt_q;
  logic [31:0] open_cnt_q;
  logic det_q;
  // Counts low line and open-string runs, and mirrors the detection hysteresis.
  always_ff @(posedge sys_clk_in) begin
    low_cnt_q <= (srst_in || data_line_in) ? 32'h0 : low_cnt_q + 32'h1;
    open_cnt_q <= (srst_in || !open_string_in) ? 32'h0 : open_cnt_q + 32'h1;
    det_q <= srst_in ? 1'b0 : open_detect_on_threshold_in ? 1'b1 : open_detect_off_threshold_in ? 1'b0 : det_q;
  end
  sequence s_quiet_open;
    !open_string_in [*5];
  endsequence
  sequence s_detect_off;
    !det_q [*5];
  endsequence
  a_reset_quiet: assert property ($past(srst_in) |-> !switch_closed_out && !full_current_out
    && !shared_fault_flag_n_oe_out && data_line_out) else $error("state not idle after reset");
  a_open_idle_high: assert property (!switch_closed_out |-> data_line_out)
    else $error("open switch passes a low");
  a_pass_copy: assert property (switch_closed_out && $past(switch_closed_out) |->
    data_line_out == $past(data_line_in)) else $error("closed switch does not copy input");
  a_line_reset_open: assert property (low_cnt_q >= RESET_CYCLES + 3 |-> !switch_closed_out)
    else $error("switch closed during long low");
  a_deglitch_hold: assert property ($rose(shared_fault_flag_n_oe_out) |-> open_cnt_q >= DEGLITCH_CYCLES)
    else $error("fault flagged before deglitch");
  a_fault_cuts_full: assert property (shared_fault_flag_n_oe_out |-> !full_current_out)
    else $error("full current during fault");
  a_recovery_cause: assert property (recovery_test_current_out |-> shared_fault_flag_n_oe_out)
    else $error("recovery current without fault");
  a_flag_in_off: assert property (!shared_fault_flag_n_in |=> !full_current_out)
    else $error("full current with flag low");
  a_flag_data_low: assert property (shared_fault_flag_n_oe_out |-> !shared_fault_flag_n_out)
    else $error("flag driven high");
  a_fault_release: assert property (s_quiet_open |-> !shared_fault_flag_n_oe_out)
    else $error("flag held after open cleared");
  a_detect_gated: assert property (s_detect_off |-> !shared_fault_flag_n_oe_out)
    else $error("fault flagged while detection off");
endmodule // cowl_slave_checker
`default_nettype wire

// ### verif/cowl_mcu_model.sv
// Controller model that drives command frames onto the one-wire data line.
`timescale 1ns/1ps
`default_nettype none
module cowl_mcu_model (
  input wire logic sys_clk_in,
  input wire logic loop_in,
  output logic line_out
);
  // Last sixteen looped-back bits, oldest first, as the controller's readback would see them.
  logic [15:0] loop_word = 16'hFFFF;
  // The line idles high from time zero.
  initial line_out = 1'b1;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // Sends a byte MSB first, half a bit period per bit, with even duty.
  task automatic send_byte(input logic [7:0] b, input int half);
    for (int i = 7; i >= 0; i--) begin
      line_out = b[i];
      wait_cyc(half / 2);
      // Loopback is read mid-bit so the one-cycle pass-through delay does not matter.
      loop_word = {loop_word[14:0], loop_in};
      wait_cyc(half - half / 2);
    end
  endtask
  // Sync byte fixes the period; the data byte may use another rate.
  // Data follows the sync at once, far inside the allowed high gap.
  task automatic send_frame(input logic [7:0] cmd, input int half);
    send_byte(8'h55, 20);
    send_byte(cmd, half);
    wait_cyc(8);
  endtask
  // Push-pull low for a whole reset span, then idle high again.
  task automatic line_reset(input int n);
    line_out = 1'b0;
    wait_cyc(n);
    line_out = 1'b1;
    wait_cyc(10);
  endtask
endmodule // cowl_mcu_model
`default_nettype wire

// ### verif/cowl_slave_test.sv
// Self-checking bench for the one-wire LED switch slave.
`timescale 1ns/1ps
`default_nettype none
module cowl_slave_test;
  localparam int RESET_CYCLES = 200;
  localparam int DEGLITCH_CYCLES = 8;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic on_thr = 1'b0;
  logic off_thr = 1'b1;
  logic open_str = 1'b0;
  logic ext_low = 1'b0;
  logic dout, oe, full, rec, sw;
  wire logic din;
  wire logic flag_n;
  int mismatches = 0;
  int total_checks = 0;
  // Shared flag wire with pull-up, pulled low by the slave or by another party.
  assign flag_n = (oe || ext_low) ? 1'b0 : 1'b1;
  // Clock at 200 MHz.
  always #2.5 sys_clk_in = ~sys_clk_in;
  cowl_mcu_model mcu (.sys_clk_in(sys_clk_in), .loop_in(dout), .line_out(din));
  cowl_slave #(
    .RESET_CYCLES(RESET_CYCLES), .SYNC_TIMEOUT_CYCLES(150), .GAP_MAX_CYCLES(300),
    .BIT_PERIOD_MIN_CYCLES(8), .BIT_PERIOD_MAX_CYCLES(80), .DEGLITCH_CYCLES(DEGLITCH_CYCLES)
  ) uut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .data_line_in(din), .data_line_out(dout),
    .open_detect_on_threshold_in(on_thr), .open_detect_off_threshold_in(off_thr),
    .open_string_in(open_str), .shared_fault_flag_n_in(flag_n), .shared_fault_flag_n_out(),
    .shared_fault_flag_n_oe_out(oe), .full_current_out(full), .recovery_test_current_out(rec),
    .switch_closed_out(sw)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Packs line out, switch, full current, recovery current and flag enable.
  function automatic logic [7:0] status();
    return {3'h0, dout, sw, full, rec, oe};
  endfunction
  task automatic frame(input logic [7:0] cmd, input logic [7:0] exp);
    mcu.send_frame(cmd, 20);
    check(status(), exp);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_power_up();
    check(status(), 8'h10);
    mcu.send_byte(8'hFF, 20);
    mcu.line_reset(RESET_CYCLES + 10);
  endtask
  // One on/off frame per slave, nearest first, then latch.
  task automatic t_store_ignore_latch();
    frame(8'h9F, 8'h18);
    check(mcu.loop_word[15:8], 8'hFF);
    check(mcu.loop_word[7:0], 8'hFF);
    frame(8'h6F, 8'h18);
    frame(8'h0F, 8'h14);
    check(mcu.loop_word[15:8], 8'h55);
    check(mcu.loop_word[7:0], 8'h0F);
    mcu.line_reset(RESET_CYCLES + 10);
  endtask
  task automatic t_off_latch();
    frame(8'h6F, 8'h1C);
    frame(8'h0F, 8'h10);
  endtask
  task automatic t_bad_rate();
    mcu.send_frame(8'h6F, 10);
    check(status(), 8'h10);
    // The rejected frame drops the receiver to idle at its data byte's second fall and no later fall follows; pause before the next frame.
    tick(200);
    frame(8'h9F, 8'h18);
  endtask
  task automatic t_abort_frame();
    mcu.send_byte(8'h55, 20);
    mcu.line_reset(RESET_CYCLES + 10);
    check(status(), 8'h10);
    frame(8'h9F, 8'h18);
    frame(8'h0F, 8'h14);
  endtask
  task automatic t_sync_timeout();
    mcu.send_byte(8'h57, 20);
    // Next frame starts after the sync timeout but before the period check would free the receiver.
    tick(1);
    frame(8'h6F, 8'h1C);
    frame(8'h9F, 8'h1C);
    frame(8'h0F, 8'h10);
    frame(8'h9F, 8'h18);
    frame(8'h0F, 8'h14);
  endtask
  task automatic t_fault();
    on_thr = 1'b1;
    off_thr = 1'b0;
    tick(4);
    open_str = 1'b1;
    tick(DEGLITCH_CYCLES - 4);
    open_str = 1'b0;
    tick(4);
    check(status(), 8'h14);
    open_str = 1'b1;
    tick(DEGLITCH_CYCLES + 4);
    check(status(), 8'h13);
    check({7'h0, flag_n}, 8'h00);
    open_str = 1'b0;
    tick(6);
    check(status(), 8'h14);
    ext_low = 1'b1;
    tick(2);
    check(status(), 8'h10);
    ext_low = 1'b0;
    tick(3);
    on_thr = 1'b0;
    off_thr = 1'b1;
    tick(4);
    open_str = 1'b1;
    tick(20);
    check(status(), 8'h14);
    open_str = 1'b0;
  endtask
  // Main sequence: reset held for 10 cycles, then every scenario.
  initial begin
    tick(10);
    srst_in = 1'b0;
    tick(2);
    t_power_up();
    t_store_ignore_latch();
    t_off_latch();
    t_bad_rate();
    t_abort_frame();
    t_sync_timeout();
    t_fault();
    complete_run();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    mismatches++;
    complete_run();
  end
endmodule // cowl_slave_test
bind cowl_slave cowl_slave_checker #(
  .RESET_CYCLES(RESET_CYCLES), .DEGLITCH_CYCLES(DEGLITCH_CYCLES)
) chk (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .data_line_in(data_line_in), .data_line_out(data_line_out),
  .open_detect_on_threshold_in(open_detect_on_threshold_in),
  .open_detect_off_threshold_in(open_detect_off_threshold_in), .open_string_in(open_string_in),
  .shared_fault_flag_n_in(shared_fault_flag_n_in), .shared_fault_flag_n_out(shared_fault_flag_n_out),
  .shared_fault_flag_n_oe_out(shared_fault_flag_n_oe_out), .full_current_out(full_current_out),
  .recovery_test_current_out(recovery_test_current_out), .switch_closed_out(switch_closed_out)
);
`default_nettype wire
